// ==== rtl/uiopl_top.sv ====
// APB-reached I/O pin logic for a four-channel UART
`timescale 1ns/1ns
module uiopl_top
  import uiopl_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NPIN-1:0] pin_in,
  output logic [NPIN-1:0] pin_out,
  output logic [NPIN-1:0] pin_oe_n,
  input wire uiopl_chan_s [CHANNELS-1:0] chan_src,
  output logic [CHANNELS-1:0] transmit_clock_in,
  output logic [CHANNELS-1:0] receive_clock_in,
  output logic [CHANNELS-1:0] clear_to_send_n,
  output logic [PAIRS-1:0] counter_clock_in,
  output logic [PAIRS-1:0] cos_request
);

  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_lvl;
  logic [7:0] pin_config_channel [CHANNELS];
  logic [7:0] output_latch [PAIRS];
  logic [AUX_W-1:0] aux_ctrl [PAIRS];
  logic [3:0] cos_flag [PAIRS];
  logic [3:0] cos_stable [PAIRS];
  logic [3:0] cos_last [PAIRS];
  logic cos_armed;
  logic [SDIV_W-1:0] sample_cnt;
  logic sample_tick;
  logic [3:0] rd_clr [PAIRS];
  logic [3:0] next_clr [PAIRS];
  logic [31:0] next_rdata;
  logic next_err;
  logic [NPIN-1:0] next_out;
  logic [NPIN-1:0] next_oe_n;
  logic wr_go;
  logic rd_go;

  function automatic logic [7:0] pair_byte(input logic [7:0] p);
    pair_byte = {p[7], p[6], p[3], p[2], p[5], p[4], p[1], p[0]};
  endfunction

  function automatic logic latch_bit(input logic [7:0] lat, input int ch, input int pn);
    logic [7:0] flat;
    flat = {lat[7], lat[6], lat[3], lat[2], lat[5], lat[4], lat[1], lat[0]};
    latch_bit = flat[(ch % 2) * PINS + pn];
  endfunction

  // Levels of one channel pair in register order
  function automatic logic [7:0] pair_level(input logic [NPIN-1:0] lv, input int pr);
    pair_level = pair_byte(lv[pr * 2 * PINS +: 2 * PINS]);
  endfunction

  function automatic logic [7:0] change_byte(input logic [3:0] flg, input logic [7:0] lvl);
    change_byte = {flg, lvl[3:0]};
  endfunction

  // Two-flop synchroniser for the pins
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_meta <= '0;
      pin_lvl <= '0;
    end else begin
      pin_meta <= pin_in;
      pin_lvl <= pin_meta;
    end
  end

  assign wr_go = psel && penable && pready && pwrite;
  assign rd_go = psel && penable && pready && !pwrite;

  // Read data and decode, taken at the setup cycle
  always_comb begin
    next_rdata = '0;
    next_err = 1'b0;
    for (int q = 0; q < PAIRS; q++) begin
      next_clr[q] = '0;
    end
    case (paddr)
      OFS_AUX_AB: next_rdata[AUX_W-1:0] = aux_ctrl[0];
      OFS_AUX_CD: next_rdata[AUX_W-1:0] = aux_ctrl[1];
      OFS_CHG_AB: begin
        next_rdata[7:0] = change_byte(cos_flag[0], pair_level(pin_lvl, 0));
        next_clr[0] = pwrite ? 4'h0 : cos_flag[0];
      end
      OFS_CHG_CD: begin
        next_rdata[7:0] = change_byte(cos_flag[1], pair_level(pin_lvl, 1));
        next_clr[1] = pwrite ? 4'h0 : cos_flag[1];
      end
      OFS_LVL_AB: next_rdata[7:0] = pair_level(pin_lvl, 0);
      OFS_LVL_CD: next_rdata[7:0] = pair_level(pin_lvl, 1);
      OFS_LATCH_AB: next_rdata = '0;
      OFS_LATCH_CD: next_rdata = '0;
      OFS_CFG_A: next_rdata[7:0] = pin_config_channel[0];
      OFS_CFG_B: next_rdata[7:0] = pin_config_channel[1];
      OFS_CFG_C: next_rdata[7:0] = pin_config_channel[2];
      OFS_CFG_D: next_rdata[7:0] = pin_config_channel[3];
      default: next_err = 1'b1;
    endcase
  end

  // APB answer: ready in the first access cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      for (int q = 0; q < PAIRS; q++) begin
        rd_clr[q] <= '0;
      end
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        pslverr <= next_err;
        prdata <= pwrite ? 32'h0000_0000 : next_rdata;
        for (int q = 0; q < PAIRS; q++) begin
          rd_clr[q] <= next_clr[q];
        end
      end else begin
        pslverr <= 1'b0;
        for (int q = 0; q < PAIRS; q++) begin
          rd_clr[q] <= '0;
        end
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int c = 0; c < CHANNELS; c++) begin
        pin_config_channel[c] <= CFG_RESET;
      end
    end else if (wr_go) begin
      case (paddr)
        OFS_CFG_A: pin_config_channel[0] <= pwdata[7:0];
        OFS_CFG_B: pin_config_channel[1] <= pwdata[7:0];
        OFS_CFG_C: pin_config_channel[2] <= pwdata[7:0];
        OFS_CFG_D: pin_config_channel[3] <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Output latches and auxiliary control
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int q = 0; q < PAIRS; q++) begin
        output_latch[q] <= LATCH_RESET;
        aux_ctrl[q] <= AUX_RESET;
      end
    end else if (wr_go) begin
      case (paddr)
        OFS_LATCH_AB: output_latch[0] <= pwdata[7:0];
        OFS_LATCH_CD: output_latch[1] <= pwdata[7:0];
        OFS_AUX_AB: aux_ctrl[0] <= pwdata[AUX_W-1:0];
        OFS_AUX_CD: aux_ctrl[1] <= pwdata[AUX_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sample_cnt <= '0;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= (sample_cnt == SAMPLE_LAST);
      sample_cnt <= (sample_cnt == SAMPLE_LAST) ? '0 : sample_cnt + 1'b1;
    end
  end

  // Change detectors on pin0 and pin1 of each channel
  always_ff @(posedge clk) begin
    if (srst) begin
      cos_armed <= 1'b0;
      for (int q = 0; q < PAIRS; q++) begin
        cos_stable[q] <= '0;
        cos_last[q] <= '0;
        cos_flag[q] <= '0;
      end
    end else begin
      if (sample_tick) begin
        cos_armed <= 1'b1;
      end
      for (int q = 0; q < PAIRS; q++) begin
        for (int k = 0; k < 4; k++) begin
          logic cur;
          logic set;
          cur = pin_lvl[(q * 2 + k / 2) * PINS + k % 2];
          set = 1'b0;
          if (sample_tick) begin
            cos_last[q][k] <= cur;
            if (!cos_armed) begin
              cos_stable[q][k] <= cur;
            end else if (cur == cos_last[q][k] && cur != cos_stable[q][k]) begin
              cos_stable[q][k] <= cur;
              set = 1'b1;
            end
          end
          cos_flag[q][k] <= (cos_flag[q][k] && !(rd_go && rd_clr[q][k])) || set;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cos_request <= '0;
    end else begin
      for (int q = 0; q < PAIRS; q++) begin
        cos_request[q] <= |(cos_flag[q] & aux_ctrl[q]);
      end
    end
  end

  // Pin drive selection
  always_comb begin
    next_out = '0;
    next_oe_n = '1;
    for (int c = 0; c < CHANNELS; c++) begin
      for (int p = 0; p < PINS; p++) begin
        logic [1:0] fld;
        logic gp;
        fld = pin_config_channel[c][2 * p +: 2];
        gp = !latch_bit(output_latch[c / 2], c, p);
        next_oe_n[c * PINS + p] = (fld == MODE_INPUT);
        case (fld)
          MODE_LATCH: begin
            if (p == PIN2 && chan_src[c].flow_ctrl_en) begin
              next_out[c * PINS + p] = chan_src[c].request_to_send_n;
            end else if (p == PIN1 && chan_src[c].flow_ctrl_en
                && pin_config_channel[c][2 * PIN2 +: 2] != MODE_LATCH) begin
              next_out[c * PINS + p] = chan_src[c].request_to_send_n;
            end else begin
              next_out[c * PINS + p] = gp;
            end
          end
          MODE_CLK_A: begin
            case (p)
              PIN3: next_out[c * PINS + p] = chan_src[c].tx_clk_16x;
              PIN2: next_out[c * PINS + p] = chan_src[c].rx_clk_1x;
              PIN1: next_out[c * PINS + p] = chan_src[c].rx_clk_16x;
              default: next_out[c * PINS + p] = chan_src[c].tx_clk_1x;
            endcase
          end
          MODE_CLK_B: begin
            case (p)
              PIN3: next_out[c * PINS + p] = chan_src[c].tx_clk_1x;
              PIN2: next_out[c * PINS + p] = chan_src[c].rx_clk_16x;
              PIN1: next_out[c * PINS + p] = chan_src[c].rx_clk_1x;
              default: next_out[c * PINS + p] = chan_src[c].tx_clk_16x;
            endcase
          end
          default: next_out[c * PINS + p] = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_out <= '0;
      pin_oe_n <= '1;
    end else begin
      pin_out <= next_out;
      pin_oe_n <= next_oe_n;
    end
  end

  // Input functions read the real pin level
  always_ff @(posedge clk) begin
    if (srst) begin
      transmit_clock_in <= '0;
      receive_clock_in <= '0;
      clear_to_send_n <= '0;
      counter_clock_in <= '0;
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        // Pin3 transmit clock unless pin3 drives
        if (pin_config_channel[c][2 * PIN3 +: 2] == MODE_INPUT) begin
          transmit_clock_in[c] <= pin_lvl[c * PINS + PIN3];
        end else begin
          transmit_clock_in[c] <= pin_lvl[c * PINS + PIN1];
        end
        receive_clock_in[c] <= pin_lvl[c * PINS + PIN2];
        clear_to_send_n[c] <= pin_lvl[c * PINS + PIN0];
      end
      for (int q = 0; q < PAIRS; q++) begin
        // Counter clock from pin1 of a and c
        counter_clock_in[q] <= pin_lvl[q * 2 * PINS + PIN1];
      end
    end
  end

endmodule

// ==== rtl/uiopl_pkg.sv ====
// Constants, types and register map for the UART I/O pin logic
package uiopl_pkg;

  localparam int CHANNELS = 4;
  localparam int PINS = 4;
  localparam int NPIN = CHANNELS * PINS;
  localparam int PAIRS = 2;
  localparam int AUX_W = 4;
  localparam int ADDR_W = 8;

  localparam logic [ADDR_W-1:0] OFS_AUX_AB = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CHG_AB = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LVL_AB = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LATCH_AB = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_AUX_CD = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CHG_CD = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_LVL_CD = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_LATCH_CD = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_CFG_A = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CFG_B = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_CFG_C = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_CFG_D = 8'h2c;

  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [AUX_W-1:0] AUX_RESET = 4'h0;

  localparam logic [1:0] MODE_INPUT = 2'b00;
  localparam logic [1:0] MODE_LATCH = 2'b01;
  localparam logic [1:0] MODE_CLK_A = 2'b10;
  localparam logic [1:0] MODE_CLK_B = 2'b11;

  localparam int PIN0 = 0;
  localparam int PIN1 = 1;
  localparam int PIN2 = 2;
  localparam int PIN3 = 3;

  localparam longint CLK_HZ = 125000000;
  localparam longint SAMPLE_HZ = 38400;
  localparam int SAMPLE_DIV = int'(CLK_HZ / SAMPLE_HZ);
  localparam int SDIV_W = 12;
  localparam logic [SDIV_W-1:0] SAMPLE_LAST = SDIV_W'(SAMPLE_DIV - 1);

  // Per-channel sources from the UART core
  typedef struct packed {
    logic tx_clk_16x;
    logic tx_clk_1x;
    logic rx_clk_16x;
    logic rx_clk_1x;
    logic request_to_send_n;
    logic flow_ctrl_en;
  } uiopl_chan_s;

endpackage

// ==== tb/uiopl_checker.sv ====
// Port checker for the UART pin logic
`timescale 1ns/1ns
module uiopl_checker
  import uiopl_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NPIN-1:0] pin_in,
  input wire logic [NPIN-1:0] pin_out,
  input wire logic [NPIN-1:0] pin_oe_n,
  input wire uiopl_chan_s [CHANNELS-1:0] chan_src,
  input wire logic [CHANNELS-1:0] clear_to_send_n,
  input wire logic [PAIRS-1:0] cos_request
);
  logic [7:0] cfga;
  logic [7:0] lat;
  logic [3:0] aux;
  logic [3:0] up;
  // Shadows of host writes
  always_ff @(posedge clk) begin
    if (srst) begin
      cfga <= 8'h00;
      lat <= 8'h00;
      aux <= 4'h0;
      up <= 4'h0;
    end else begin
      if (up != 4'hf) up <= up + 4'h1;
      if (psel && penable && pready && pwrite) begin
        if (paddr == OFS_CFG_A) cfga <= pwdata[7:0];
        if (paddr == OFS_LATCH_AB) lat <= pwdata[7:0];
        if (paddr == OFS_AUX_AB) aux <= pwdata[3:0];
      end
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (srst);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence held_s;
    $stable(cfga) && $stable(lat);
  endsequence
  AST_PREADY_NEXT: assert property (setup_s |=> pready)
    else $error("no answer");
  AST_PREADY_ONLY: assert property (pready |-> $past(psel && !penable))
    else $error("stray answer");
  AST_UNMAPPED: assert property (setup_s ##0 paddr > OFS_CFG_D |=> pslverr && prdata == 32'h0)
    else $error("not refused");
  AST_BYTE_WIDE: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper bits set");
  AST_RESET_INPUTS: assert property ($past(srst) |-> &pin_oe_n)
    else $error("pin driven after reset");
  AST_INPUT_OFF: assert property (held_s ##0 cfga[1:0] == MODE_INPUT |-> pin_oe_n[0])
    else $error("input pin driven");
  AST_LATCH_DRIVE: assert property (held_s ##0 cfga[1:0] == MODE_LATCH |->
    pin_out[0] == !lat[0] && !pin_oe_n[0]) else $error("latch not driven");
  AST_CLOCK_OUT: assert property (held_s ##0 cfga[1:0] == MODE_CLK_A |->
    pin_out[0] == $past(chan_src[0].tx_clk_1x)) else $error("clock not driven");
  AST_CTS_IN: assert property ((up == 4'hf && cfga[1:0] == MODE_INPUT &&
    $stable(pin_in[0])) [*4] |-> clear_to_send_n[0] == pin_in[0]) else $error("cts wrong");
  AST_COS_GATE: assert property (aux == 4'h0 && $stable(aux) |-> !cos_request[0])
    else $error("request while disabled");
endmodule
bind uiopl_top uiopl_checker uiopl_checker_inst (.clk(clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n), .chan_src(chan_src), .clear_to_send_n(clear_to_send_n),
  .cos_request(cos_request));

// ==== tb/uiopl_pins.sv ====
// Far-side pin lines meeting the block's drivers
`timescale 1ns/1ns
module uiopl_pins
  import uiopl_pkg::*;
(
  input wire logic [NPIN-1:0] pin_out,
  input wire logic [NPIN-1:0] pin_oe_n,
  input wire logic [NPIN-1:0] ext_lvl,
  output logic [NPIN-1:0] pin_in
);
  // Released pins follow the external driver
  assign pin_in = (pin_oe_n & ext_lvl) | (~pin_oe_n & pin_out);
endmodule

// ==== tb/test_uiopl_top.sv ====
// Self-checking bench for the UART pin logic
`timescale 1ns/1ns
module test_uiopl_top
  import uiopl_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [NPIN-1:0] pin_in, pin_out, pin_oe_n, old, q;
  logic [NPIN-1:0] ext_lvl = '0;
  logic [PAIRS-1:0] cos_request;
  logic [CHANNELS-1:0] tx_in, rx_in;
  logic [PAIRS-1:0] ct_in;
  uiopl_chan_s [CHANNELS-1:0] chan_src = '0;
  uiopl_chan_s s;
  logic [7:0] lat, cfg;
  logic [32:0] exq[$];
  int miscompares = 0;
  int checks_done = 0;
  uiopl_top uiopl_top_inst (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .chan_src(chan_src), .transmit_clock_in(tx_in), .receive_clock_in(rx_in),
    .clear_to_send_n(), .counter_clock_in(ct_in), .cos_request(cos_request));
  uiopl_pins uiopl_pins_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_lvl(ext_lvl),
    .pin_in(pin_in));
  initial forever #4 clk = ~clk;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
    input logic [32:0] e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    if (!w) exq.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      end_of_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00, {25'h0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 33'h0);
  endtask
  function automatic logic [7:0] pb(input logic [NPIN-1:0] p, input int b);
    return {p[b+7], p[b+6], p[b+3], p[b+2], p[b+5], p[b+4], p[b+1], p[b]};
  endfunction
  function automatic logic [7:0] cb(input logic [NPIN-1:0] o, n, input int b);
    logic [7:0] f;
    logic [7:0] v;
    f = pb(o ^ n, b);
    v = pb(n, b);
    return {f[3:0], v[3:0]};
  endfunction
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk("prdata", {pslverr, prdata}, exq.pop_front());
    end
  end
  initial begin
    void'($urandom(82314));
    ext_lvl <= NPIN'($urandom);
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 4; i++) rd(OFS_CFG_A + 8'(4 * i), CFG_RESET);
    xfer(1'b0, 8'h30, 8'h00, {1'b1, 32'h0});
    $display("test reset done");
    repeat (3300) @(posedge clk);
    old = ext_lvl;
    ext_lvl <= NPIN'($urandom);
    repeat (10) @(posedge clk);
    rd(OFS_LVL_AB, pb(ext_lvl, 0));
    rd(OFS_LVL_CD, pb(ext_lvl, 8));
    chk("transmit_clock_in", {29'h0, tx_in}, {29'h0, ext_lvl[15], ext_lvl[11], ext_lvl[7], ext_lvl[3]});
    chk("receive_clock_in", {29'h0, rx_in}, {29'h0, ext_lvl[14], ext_lvl[10], ext_lvl[6], ext_lvl[2]});
    chk("counter_clock_in", {31'h0, ct_in}, {31'h0, ext_lvl[9], ext_lvl[1]});
    repeat (7000) @(posedge clk);
    for (int p = 0; p < 2; p++) begin
      rd(OFS_CHG_AB + 8'(16 * p), cb(old, ext_lvl, 8 * p));
      rd(OFS_CHG_AB + 8'(16 * p), cb(ext_lvl, ext_lvl, 8 * p));
    end
    wr(OFS_AUX_AB, 8'h01);
    old = ext_lvl;
    ext_lvl <= ~ext_lvl;
    repeat (7000) @(posedge clk);
    chk("cos_request", {31'h0, cos_request}, 33'h1);
    rd(OFS_CHG_AB, cb(old, ext_lvl, 0));
    repeat (3) @(posedge clk);
    chk("cos_request", {31'h0, cos_request}, 33'h0);
    $display("test change done");
    for (int c = 0; c < 4; c++) chan_src[c] <= uiopl_chan_s'({5'($urandom), 1'b0});
    @(posedge clk);
    for (int p = 0; p < 2; p++) begin
      for (int m = 1; m < 4; m++) begin
        lat = 8'($urandom);
        cfg = {4{2'(m)}};
        s = chan_src[2 * p];
        wr(OFS_LATCH_AB + 8'(16 * p), lat);
        wr(OFS_CFG_A + 8'(8 * p), cfg);
        rd(OFS_CFG_A + 8'(8 * p), cfg);
        q = ext_lvl;
        case (m)
          1: q[8 * p +: 4] = ~{lat[5], lat[4], lat[1], lat[0]};
          2: q[8 * p +: 4] = {s.tx_clk_16x, s.rx_clk_1x, s.rx_clk_16x, s.tx_clk_1x};
          default: q[8 * p +: 4] = {s.tx_clk_1x, s.rx_clk_16x, s.rx_clk_1x, s.tx_clk_16x};
        endcase
        rd(OFS_LVL_AB + 8'(16 * p), pb(q, 8 * p));
        chk("transmit_clock_in", {32'h0, tx_in[2 * p]}, {32'h0, q[8 * p + 1]});
        chk("receive_clock_in", {32'h0, rx_in[2 * p]}, {32'h0, q[8 * p + 2]});
        chk("counter_clock_in", {32'h0, ct_in[p]}, {32'h0, q[8 * p + 1]});
      end
    end
    chan_src[0] <= uiopl_chan_s'({5'($urandom), 1'b1});
    lat = 8'($urandom);
    @(posedge clk);
    s = chan_src[0];
    wr(OFS_LATCH_AB, lat);
    for (int m = 0; m < 2; m++) begin
      wr(OFS_CFG_A, m ? 8'h04 : 8'h14);
      repeat (4) @(posedge clk);
      q = ext_lvl;
      q[2] = m ? ext_lvl[2] : s.request_to_send_n;
      q[1] = m ? s.request_to_send_n : ~lat[1];
      rd(OFS_LVL_AB, pb(q, 0));
      chk("transmit_clock_in", {32'h0, tx_in[0]}, {32'h0, q[3]});
    end
    $display("test outputs done");
    end_of_test();
  end
endmodule
